//--- logic/ppif_params.svh
// Register offsets, field positions, reset values and timing counts of the port pull and flag block
`ifndef PPIF_PARAMS_SVH
`define PPIF_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PPIF_OFF_P0_FLAGS    8'h89
`define PPIF_OFF_P1_FLAGS    8'h8a
`define PPIF_OFF_P2_FLAGS    8'h8b
`define PPIF_OFF_EDGE_SEL    8'h8c
`define PPIF_OFF_P1_IRQ_EN   8'h8d
`define PPIF_OFF_P0_TRI_SEL  8'h8f
`define PPIF_OFF_IRQ_STATUS  8'he0
`define PPIF_OFF_IRQ_MASK    8'he1
`define PPIF_OFF_P2_SETUP    8'hf7

// ****************************************
// Field positions
// ****************************************
`define PPIF_POS_PULL_DIR_P2 7
`define PPIF_POS_PULL_DIR_P1 6
`define PPIF_POS_PULL_DIR_P0 5
`define PPIF_POS_USB_RESUME  7
`define PPIF_POS_P0_UNUSED   6
`define PPIF_POS_EDGE_P0     0
`define PPIF_POS_EDGE_P1     1
`define PPIF_POS_EDGE_P2     2
`define PPIF_POS_EV_P0       0
`define PPIF_POS_EV_P1       1
`define PPIF_POS_EV_P2       2
`define PPIF_POS_EV_RESUME   3

// ****************************************
// Reset values and masks
// ****************************************
`define PPIF_RST_P2_SETUP    8'h00
`define PPIF_RST_FLAGS       8'h00
`define PPIF_RST_EDGE_SEL    3'h0
`define PPIF_RST_P1_IRQ_EN   8'h00
`define PPIF_RST_P0_TRI_SEL  8'h00
`define PPIF_RST_IRQ         4'h0
`define PPIF_MASK_P2_FLAGS   8'h1f
`define PPIF_MASK_P1_PULLED  8'hfc

// ****************************************
// Timing counts
// ****************************************
`define PPIF_SYNC_FILL       2'h3

`endif

//--- logic/ppif_pkg.sv
// Types shared by the port pull and flag block
package ppif_pkg;

	typedef logic [7:0] ppif_byte_t;

	typedef enum logic
	{
		PPIF_EDGE_RISE = 1'b0,
		PPIF_EDGE_FALL = 1'b1
	} ppif_edge_t;

endpackage

//--- logic/ppif_top.sv
// Port pull-direction setup, per-pin pending flags and port interrupt output
`timescale 1ns/1ps

`include "ppif_params.svh"

module ppif_top
	import ppif_pkg::*;
#(
	parameter bit USB_VARIANT = 1'b0
)
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,

	// Register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rd_data_o,

	// Pin inputs
	input  wire logic [7:0] port0_pins_i,
	input  wire logic [7:0] port1_pins_i,
	input  wire logic [4:0] port2_pins_i,

	// Neighbouring logic on the same clock
	input  wire logic [7:0] port1_tristate_sel_i,
	input  wire logic       usb_resume_i,
	input  wire logic       usb_suspend_i,

	// Pull resistor controls
	output logic      [7:0] port0_pull_up_o,
	output logic      [7:0] port0_pull_down_o,
	output logic      [7:0] port1_pull_up_o,
	output logic      [7:0] port1_pull_down_o,
	output logic      [4:0] port2_pull_up_o,
	output logic      [4:0] port2_pull_down_o,

	// Interrupt
	output logic            irq_o
);

	// ****************************************
	// Helpers
	// ****************************************

	// A settled edge: second and third stage agree and differ from the last settled level
	function automatic ppif_byte_t edge_hits
	(
		input ppif_byte_t old_lvl,
		input ppif_byte_t s2,
		input ppif_byte_t s3,
		input ppif_edge_t pol
	);
		if (pol == PPIF_EDGE_FALL)
			edge_hits = old_lvl & ~s2 & ~s3;
		else
			edge_hits = ~old_lvl & s2 & s3;
	endfunction

	// Write-zero-to-clear with hardware set taking priority over the clear
	function automatic ppif_byte_t flag_next
	(
		input ppif_byte_t cur,
		input ppif_byte_t set,
		input logic       wr_hit,
		input ppif_byte_t wdata,
		input ppif_byte_t keep
	);
		ppif_byte_t base;
		base = wr_hit ? (cur & wdata) : cur;
		flag_next = (base | set) & keep;
	endfunction

	// ****************************************
	// Registers and decode
	// ****************************************
	ppif_byte_t p2_setup_r;
	logic [2:0] edge_sel_r;
	ppif_byte_t p1_irq_en_r;
	ppif_byte_t p0_tri_sel_r;
	logic [3:0] irq_mask_r;
	logic [3:0] irq_status_r;
	logic [3:0] irq_status_nxt;
	ppif_byte_t p0_flags_r;
	ppif_byte_t p1_flags_r;
	ppif_byte_t p2_flags_r;
	ppif_byte_t rd_data_r;
	logic       irq_r;

	logic       wr_p0_flags;
	logic       wr_p1_flags;
	logic       wr_p2_flags;
	logic       rd_irq_status;
	ppif_byte_t p0_keep;

	assign wr_p0_flags   = wr_i && (addr_i == `PPIF_OFF_P0_FLAGS);
	assign wr_p1_flags   = wr_i && (addr_i == `PPIF_OFF_P1_FLAGS);
	assign wr_p2_flags   = wr_i && (addr_i == `PPIF_OFF_P2_FLAGS);
	assign rd_irq_status = rd_i && (addr_i == `PPIF_OFF_IRQ_STATUS);
	// Bit 6 is unused on the USB variant and stays zero
	assign p0_keep       = USB_VARIANT ? ~(8'h01 << `PPIF_POS_P0_UNUSED) : 8'hff;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p2_setup_r <= `PPIF_RST_P2_SETUP;
		else if (wr_i && (addr_i == `PPIF_OFF_P2_SETUP))
			p2_setup_r <= wr_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			edge_sel_r <= `PPIF_RST_EDGE_SEL;
		else if (wr_i && (addr_i == `PPIF_OFF_EDGE_SEL))
			edge_sel_r <= wr_data_i[2:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p1_irq_en_r <= `PPIF_RST_P1_IRQ_EN;
		else if (wr_i && (addr_i == `PPIF_OFF_P1_IRQ_EN))
			p1_irq_en_r <= wr_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p0_tri_sel_r <= `PPIF_RST_P0_TRI_SEL;
		else if (wr_i && (addr_i == `PPIF_OFF_P0_TRI_SEL))
			p0_tri_sel_r <= wr_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_r <= `PPIF_RST_IRQ;
		else if (wr_i && (addr_i == `PPIF_OFF_IRQ_MASK))
			irq_mask_r <= wr_data_i[3:0];
	end

	// ****************************************
	// Pin synchroniser
	// ****************************************
	// Three stages per pin; a level counts once stages two and three agree,
	// which also rejects a one-cycle glitch reaching the second stage.
	logic [20:0] pins_s1_r;
	logic [20:0] pins_s2_r;
	logic [20:0] pins_s3_r;
	logic [20:0] pins_lvl_r;
	logic [1:0]  fill_r;
	logic        armed;

	assign armed = (fill_r == `PPIF_SYNC_FILL);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pins_s1_r <= 21'h00_0000;
			pins_s2_r <= 21'h00_0000;
			pins_s3_r <= 21'h00_0000;
		end
		else
		begin
			pins_s1_r <= {port2_pins_i, port1_pins_i, port0_pins_i};
			pins_s2_r <= pins_s1_r;
			pins_s3_r <= pins_s2_r;
		end
	end

	// Until the pipeline holds real samples the settled level follows stage two,
	// so a pin that is high out of reset gives no false rising edge.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fill_r <= 2'h0;
		else if (!armed)
			fill_r <= fill_r + 2'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pins_lvl_r <= 21'h00_0000;
		else if (!armed)
			pins_lvl_r <= pins_s2_r;
		else
			pins_lvl_r <= (pins_s2_r & pins_s3_r) | (pins_lvl_r & (pins_s2_r | pins_s3_r));
	end

	// ****************************************
	// Edge detection and flag sets
	// ****************************************
	ppif_byte_t p0_set;
	ppif_byte_t p1_set;
	ppif_byte_t p2_set;
	ppif_byte_t p0_edges;
	ppif_byte_t p2_edges;
	logic       resume_set;

	assign p0_edges = edge_hits(pins_lvl_r[7:0], pins_s2_r[7:0], pins_s3_r[7:0],
		ppif_edge_t'(edge_sel_r[`PPIF_POS_EDGE_P0]));
	assign p2_edges = edge_hits({3'h0, pins_lvl_r[20:16]}, {3'h0, pins_s2_r[20:16]},
		{3'h0, pins_s3_r[20:16]}, ppif_edge_t'(edge_sel_r[`PPIF_POS_EDGE_P2]));
	assign p1_set   = armed ? edge_hits(pins_lvl_r[15:8], pins_s2_r[15:8], pins_s3_r[15:8],
		ppif_edge_t'(edge_sel_r[`PPIF_POS_EDGE_P1])) : 8'h00;
	assign p2_set   = armed ? (p2_edges & `PPIF_MASK_P2_FLAGS) : 8'h00;

	// On the USB variant pins 7 and 6 give no flag; bit 7 reports resume in suspend
	assign resume_set = USB_VARIANT && usb_resume_i && usb_suspend_i;

	always_comb
	begin
		p0_set = armed ? p0_edges : 8'h00;
		if (USB_VARIANT)
		begin
			p0_set[`PPIF_POS_USB_RESUME] = resume_set;
			p0_set[`PPIF_POS_P0_UNUSED]  = 1'b0;
		end
	end

	// ****************************************
	// Pending flags
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p0_flags_r <= `PPIF_RST_FLAGS;
		else
			p0_flags_r <= flag_next(p0_flags_r, p0_set, wr_p0_flags, wr_data_i, p0_keep);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p1_flags_r <= `PPIF_RST_FLAGS;
		else
			p1_flags_r <= flag_next(p1_flags_r, p1_set, wr_p1_flags, wr_data_i, 8'hff);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			p2_flags_r <= `PPIF_RST_FLAGS;
		else
			p2_flags_r <= flag_next(p2_flags_r, p2_set, wr_p2_flags, wr_data_i, `PPIF_MASK_P2_FLAGS);
	end

	// ****************************************
	// Interrupt status and output
	// ****************************************
	// A new event in the same cycle as the clearing read survives.
	always_comb
	begin
		irq_status_nxt = rd_irq_status ? 4'h0 : irq_status_r;
		irq_status_nxt[`PPIF_POS_EV_P0]     = irq_status_nxt[`PPIF_POS_EV_P0] | (|(p0_set & 8'h7f));
		irq_status_nxt[`PPIF_POS_EV_P1]     = irq_status_nxt[`PPIF_POS_EV_P1] | (|(p1_set & p1_irq_en_r));
		irq_status_nxt[`PPIF_POS_EV_P2]     = irq_status_nxt[`PPIF_POS_EV_P2] | (|p2_set);
		irq_status_nxt[`PPIF_POS_EV_RESUME] = irq_status_nxt[`PPIF_POS_EV_RESUME] | (|(p0_set & 8'h80));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status_r <= `PPIF_RST_IRQ;
		else
			irq_status_r <= irq_status_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_status_r & irq_mask_r);
	end

	assign irq_o = irq_r;

	// ****************************************
	// Read port
	// ****************************************
	// Unmapped addresses read zero; data stands for exactly one cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !rd_i)
			rd_data_r <= 8'h00;
		else
		begin
			unique case (addr_i)
				`PPIF_OFF_P0_FLAGS:   rd_data_r <= p0_flags_r;
				`PPIF_OFF_P1_FLAGS:   rd_data_r <= p1_flags_r;
				`PPIF_OFF_P2_FLAGS:   rd_data_r <= p2_flags_r & `PPIF_MASK_P2_FLAGS;
				`PPIF_OFF_EDGE_SEL:   rd_data_r <= {5'h00, edge_sel_r};
				`PPIF_OFF_P1_IRQ_EN:  rd_data_r <= p1_irq_en_r;
				`PPIF_OFF_P0_TRI_SEL: rd_data_r <= p0_tri_sel_r;
				`PPIF_OFF_IRQ_STATUS: rd_data_r <= {4'h0, irq_status_r};
				`PPIF_OFF_IRQ_MASK:   rd_data_r <= {4'h0, irq_mask_r};
				`PPIF_OFF_P2_SETUP:   rd_data_r <= p2_setup_r;
				default:              rd_data_r <= 8'h00;
			endcase
		end
	end

	assign rd_data_o = rd_data_r;

	// ****************************************
	// Pull resistor controls
	// ****************************************
	ppif_byte_t p0_pu_r;
	ppif_byte_t p0_pd_r;
	ppif_byte_t p1_pu_r;
	ppif_byte_t p1_pd_r;
	logic [4:0] p2_pu_r;
	logic [4:0] p2_pd_r;
	ppif_byte_t p0_pulled;
	ppif_byte_t p1_pulled;
	logic [4:0] p2_pulled;
	logic       dir_p0;
	logic       dir_p1;
	logic       dir_p2;

	assign p0_pulled = ~p0_tri_sel_r;
	// Port-1 pins 0 and 1 carry no resistor at all
	assign p1_pulled = ~port1_tristate_sel_i & `PPIF_MASK_P1_PULLED;
	assign p2_pulled = ~p2_setup_r[4:0];
	assign dir_p0    = p2_setup_r[`PPIF_POS_PULL_DIR_P0];
	assign dir_p1    = p2_setup_r[`PPIF_POS_PULL_DIR_P1];
	assign dir_p2    = p2_setup_r[`PPIF_POS_PULL_DIR_P2];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			p0_pu_r <= 8'h00;
			p0_pd_r <= 8'h00;
		end
		else
		begin
			p0_pu_r <= p0_pulled & {8{~dir_p0}};
			p0_pd_r <= p0_pulled & {8{dir_p0}};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			p1_pu_r <= 8'h00;
			p1_pd_r <= 8'h00;
		end
		else
		begin
			p1_pu_r <= p1_pulled & {8{~dir_p1}};
			p1_pd_r <= p1_pulled & {8{dir_p1}};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			p2_pu_r <= 5'h00;
			p2_pd_r <= 5'h00;
		end
		else
		begin
			p2_pu_r <= p2_pulled & {5{~dir_p2}};
			p2_pd_r <= p2_pulled & {5{dir_p2}};
		end
	end

	assign port0_pull_up_o   = p0_pu_r;
	assign port0_pull_down_o = p0_pd_r;
	assign port1_pull_up_o   = p1_pu_r;
	assign port1_pull_down_o = p1_pd_r;
	assign port2_pull_up_o   = p2_pu_r;
	assign port2_pull_down_o = p2_pd_r;

endmodule

//--- test/ppif_pin_model.sv
// Model of the external circuitry that drives one group of port pins
`timescale 1ns/1ps

module ppif_pin_model
#(
	parameter int W = 8
)
(
	// Clock
	input  wire logic         clk_i,
	// Drive and pull controls
	input  wire logic [W-1:0] drv_i,
	input  wire logic [W-1:0] en_i,
	input  wire logic [W-1:0] up_i,
	input  wire logic [W-1:0] dn_i,
	// Pin levels
	output logic      [W-1:0] pin_o
);
	logic [W-1:0] last_r = '0;

	// A floating pin shows the inverse of its last level, never a settled guess
	always @(posedge clk_i)
	begin
		last_r <= pin_o;
	end

	assign pin_o = (en_i & drv_i) | (~en_i & (up_i | (~dn_i & ~last_r)));
endmodule

//--- test/ppif_chk.sv
// Port-level assertions of the port pull and flag block
`timescale 1ns/1ps

module ppif_chk
(
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rd_data_o,
	// Pull controls and interrupt
	input wire logic [7:0] port1_tristate_sel_i,
	input wire logic [7:0] port0_pull_up_o,
	input wire logic [7:0] port0_pull_down_o,
	input wire logic [7:0] port1_pull_up_o,
	input wire logic [7:0] port1_pull_down_o,
	input wire logic [4:0] port2_pull_up_o,
	input wire logic [4:0] port2_pull_down_o,
	input wire logic       irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic rd_p2_r;

	always_ff @(posedge clk_i)
	begin
		rd_p2_r <= rd_i && addr_i == 8'h8b;
	end

	property p_rst_out;
		$fell(rst_i) |-> rd_data_o == 8'h00 && !irq_o;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
	property p_rd_idle;
		!$past(rd_i) |-> rd_data_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	property p_p2_hi;
		rd_p2_r |-> rd_data_o[7:5] == 3'h0;
	endproperty
	a_p2_hi: assert property (p_p2_hi) else $error("port2 flag high bits set");
	property p_excl;
		((port0_pull_up_o & port0_pull_down_o) | (port1_pull_up_o & port1_pull_down_o)) == 8'h00
			&& (port2_pull_up_o & port2_pull_down_o) == 5'h00;
	endproperty
	a_excl: assert property (p_excl) else $error("pull up and down together");
	property p_p1_low;
		(port1_pull_up_o[1:0] | port1_pull_down_o[1:0]) == 2'h0;
	endproperty
	a_p1_low: assert property (p_p1_low) else $error("port1 pins 1:0 pulled");
	property p_p1_mode;
		!$past(rst_i) && $stable(port1_tristate_sel_i)
			|-> (port1_pull_up_o | port1_pull_down_o) == (~port1_tristate_sel_i & 8'hfc);
	endproperty
	a_p1_mode: assert property (p_p1_mode) else $error("port1 pulled set wrong");
	property p_p2_wr;
		logic [7:0] d;
		(wr_i && addr_i == 8'hf7, d = wr_data_i) |-> ##2 port2_pull_up_o == (~d[4:0] & {5{~d[7]}})
			&& port2_pull_down_o == (~d[4:0] & {5{d[7]}});
	endproperty
	a_p2_wr: assert property (p_p2_wr) else $error("port2 pulls wrong after write");
	property p_p0_wr;
		logic [7:0] d;
		(wr_i && addr_i == 8'h8f, d = wr_data_i) |-> ##2 (port0_pull_up_o | port0_pull_down_o) == ~d;
	endproperty
	a_p0_wr: assert property (p_p0_wr) else $error("port0 pulled set wrong");

	c_irq: cover property ($rose(irq_o));
	c_rd: cover property (rd_p2_r && rd_data_o != 8'h00);
	c_wr: cover property (wr_i && addr_i == 8'hf7);
endmodule

bind ppif_top ppif_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .port1_tristate_sel_i(port1_tristate_sel_i),
	.port0_pull_up_o(port0_pull_up_o), .port0_pull_down_o(port0_pull_down_o),
	.port1_pull_up_o(port1_pull_up_o), .port1_pull_down_o(port1_pull_down_o),
	.port2_pull_up_o(port2_pull_up_o), .port2_pull_down_o(port2_pull_down_o), .irq_o(irq_o));

//--- test/ppif_tb_top.sv
// Self-checking testbench of the port pull and flag block
`timescale 1ns/1ps

module ppif_tb_top;
	logic       clk_i = 0;
	logic       rst_i = 1;
	logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, sel = 8'h30;
	logic       wr_i = 0, rd_i = 0, irq_o;
	logic       usb_resume_i = 0, usb_suspend_i = 0;
	logic [7:0] pin_en = 8'hff, usb_rd;
	logic [7:0] p0_drv = 8'h00, p1_drv = 8'h00, p0, p1, p0u, p0d, p1u, p1d;
	logic [4:0] p2_drv = 5'h00, p2, p2u, p2d;
	int         bad_count = 0;
	int         checks = 0;

	initial forever #2 clk_i = ~clk_i;

	ppif_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
		.rd_i(rd_i), .rd_data_o(rd_data_o), .port0_pins_i(p0), .port1_pins_i(p1), .port2_pins_i(p2),
		.port1_tristate_sel_i(sel), .usb_resume_i(usb_resume_i), .usb_suspend_i(usb_suspend_i),
		.port0_pull_up_o(p0u), .port0_pull_down_o(p0d), .port1_pull_up_o(p1u),
		.port1_pull_down_o(p1d), .port2_pull_up_o(p2u), .port2_pull_down_o(p2d), .irq_o(irq_o));
	// USB build on the same bus and pins; the tests judge only its read data, the bound checker all its outputs
	ppif_top #(.USB_VARIANT(1'b1)) u_usb (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(usb_rd), .port0_pins_i(p0),
		.port1_pins_i(p1), .port2_pins_i(p2), .port1_tristate_sel_i(sel), .usb_resume_i(usb_resume_i),
		.usb_suspend_i(usb_suspend_i), .port0_pull_up_o(), .port0_pull_down_o(), .port1_pull_up_o(),
		.port1_pull_down_o(), .port2_pull_up_o(), .port2_pull_down_o(), .irq_o());
	ppif_pin_model u_p0 (.clk_i(clk_i), .drv_i(p0_drv), .en_i(pin_en), .up_i(p0u), .dn_i(p0d),
		.pin_o(p0));
	ppif_pin_model u_p1 (.clk_i(clk_i), .drv_i(p1_drv), .en_i(pin_en), .up_i(p1u), .dn_i(p1d),
		.pin_o(p1));
	ppif_pin_model #(.W(5)) u_p2 (.clk_i(clk_i), .drv_i(p2_drv), .en_i(pin_en[4:0]), .up_i(p2u), .dn_i(p2d),
		.pin_o(p2));

	task automatic wrap_up;
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data is looked at only in the cycle right after the strobe
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rd_data_o, exp, "read data");
	endtask

	task automatic t_reset_vals;
		rdc(8'h89, 8'h00);
		rdc(8'h8a, 8'h00);
		rdc(8'h8b, 8'h00);
		rdc(8'hf7, 8'h00);
		rdc(8'he0, 8'h00);
		wr(8'h55, 8'hff);
		rdc(8'h55, 8'h00);
		chk(p0u, 8'hff, "port0 pull up");
		chk(p1u, 8'hcc, "port1 pull up");
		chk({3'h0, p2u}, 8'h1f, "port2 pull up");
	endtask

	task automatic t_pull;
		wr(8'hf7, 8'he5);
		repeat (3) @(posedge clk_i);
		chk({3'h0, p2d}, 8'h1a, "port2 pull down");
		chk(p0d, 8'hff, "port0 pull down");
		chk(p1d, 8'hcc, "port1 pull down");
		chk(p1u | {3'h0, p2u} | p0u, 8'h00, "pull up left on");
		rdc(8'hf7, 8'he5);
		wr(8'h8f, 8'h0f);
		wr(8'hf7, 8'h00);
		sel <= 8'h0c;
		repeat (3) @(posedge clk_i);
		chk(p0u, 8'hf0, "port0 pulled pins");
		chk(p1u, 8'hf0, "port1 pulled pins");
		chk({3'h0, p2u}, 8'h1f, "port2 pulled pins");
	endtask

	// Both edge selects: correct edge sets, opposite edge does not, write 1 keeps, write 0 clears
	task automatic t_edges;
		logic [7:0] ad [3];
		logic [7:0] pat [3];
		ad = '{8'h89, 8'h8a, 8'h8b};
		pat = '{8'ha5, 8'h5a, 8'h15};
		for (int pol = 0; pol < 2; pol++)
		begin
			wr(8'h8c, pol ? 8'h07 : 8'h00);
			p0_drv <= {8{pol[0]}};
			p1_drv <= {8{pol[0]}};
			p2_drv <= {5{pol[0]}};
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < 3; i++) wr(ad[i], 8'h00);
			p0_drv <= p0_drv ^ pat[0];
			p1_drv <= p1_drv ^ pat[1];
			p2_drv <= p2_drv ^ pat[2][4:0];
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < 3; i++) rdc(ad[i], pat[i]);
			for (int i = 0; i < 3; i++) wr(ad[i], 8'hff);
			for (int i = 0; i < 3; i++) rdc(ad[i], pat[i]);
			for (int i = 0; i < 3; i++) wr(ad[i], 8'h00);
			for (int i = 0; i < 3; i++) rdc(ad[i], 8'h00);
			p0_drv <= {8{pol[0]}};
			p1_drv <= {8{pol[0]}};
			p2_drv <= {5{pol[0]}};
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < 3; i++) rdc(ad[i], 8'h00);
		end
	endtask

	task automatic t_irq;
		wr(8'h8c, 8'h00);
		p1_drv <= 8'h00;
		repeat (8) @(posedge clk_i);
		wr(8'h8a, 8'h00);
		rdc(8'he0, 8'h0d);
		p1_drv <= 8'h04;
		repeat (8) @(posedge clk_i);
		rdc(8'h8a, 8'h04);
		rdc(8'he0, 8'h00);
		wr(8'h8d, 8'hff);
		p1_drv <= 8'h0c;
		repeat (8) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, "irq while masked");
		wr(8'he1, 8'h02);
		repeat (3) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h01, "irq not raised");
		rdc(8'he0, 8'h02);
		repeat (3) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, "irq not cleared");
	endtask

	// USB build: pins 7 and 6 give no flag, resume counts only during suspend
	task automatic t_usb;
		p0_drv <= 8'h00;
		repeat (8) @(posedge clk_i);
		wr(8'h89, 8'h00);
		p0_drv <= 8'hc1;
		repeat (8) @(posedge clk_i);
		usb_resume_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdc(8'h89, 8'hc1);
		chk(usb_rd, 8'h01, "usb port0 flags");
		@(posedge clk_i);
		usb_suspend_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		usb_resume_i <= 1'b0;
		usb_suspend_i <= 1'b0;
		rdc(8'h89, 8'hc1);
		chk(usb_rd, 8'h81, "usb resume flag");
		wr(8'h89, 8'h7f);
		rdc(8'h89, 8'h41);
		chk(usb_rd, 8'h01, "usb resume clear");
	endtask

	// Released pins settle to their pull level; floating tristate pins must never flag
	task automatic t_float;
		p0_drv <= 8'h00;
		repeat (8) @(posedge clk_i);
		wr(8'h89, 8'h00);
		wr(8'h8a, 8'h00);
		pin_en <= 8'h00;
		repeat (8) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h01, "irq from pulled pins");
		rdc(8'h89, 8'hf0);
		rdc(8'h8a, 8'hf0);
		rdc(8'h8b, 8'h00);
	endtask

	// Reset in mid-run with every pin high: no flag may appear once the synchroniser refills
	task automatic t_rst;
		@(posedge clk_i);
		rst_i <= 1'b1;
		pin_en <= 8'hff;
		p0_drv <= 8'hff;
		p1_drv <= 8'hff;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rdc(8'h89, 8'h00);
		rdc(8'h8a, 8'h00);
		rdc(8'h8b, 8'h00);
		rdc(8'he0, 8'h00);
		rdc(8'hf7, 8'h00);
		chk({7'h00, irq_o}, 8'h00, "irq after reset");
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end

	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset_vals();
		t_pull();
		t_edges();
		t_irq();
		t_usb();
		t_float();
		t_rst();
		wrap_up();
	end
endmodule
